// File: common/dyn_pkg.sv
// Constants for the dynamics quick-release, gate slope and gain readout block
package dyn_pkg;
   localparam int          REG_AW          = 8;
   localparam int          REG_DW          = 16;
   localparam logic [7:0]  QR_SET_ADDR     = 8'h22;
   localparam logic [7:0]  GATE_START_ADDR = 8'h23;
   localparam logic [7:0]  LIVE_GAIN_ADDR  = 8'h24;

   // Field positions and widths
   localparam int          QR_THR_LSB      = 2;
   localparam int          QR_THR_W        = 2;
   localparam int          QR_DCY_LSB      = 0;
   localparam int          QR_DCY_W        = 2;
   localparam int          GATE_EXP_LSB    = 8;
   localparam int          GATE_EXP_W      = 2;
   localparam int          LO_COMP_LSB     = 5;
   localparam int          LO_COMP_W       = 3;
   localparam int          START_GAIN_LSB  = 0;
   localparam int          START_GAIN_W    = 5;

   // Reset values
   localparam logic [1:0]  QR_THR_RST      = 2'h0;
   localparam logic [1:0]  QR_DCY_RST      = 2'h0;
   localparam logic [1:0]  GATE_EXP_RST    = 2'h0;
   localparam logic [2:0]  LO_COMP_RST     = 3'h0;
   localparam logic [4:0]  START_GAIN_RST  = 5'h00;
   localparam logic [15:0] LIVE_GAIN_RST   = 16'h0000;

   // Crest-factor threshold: base plus step per code, in dB
   localparam logic [4:0]  THR_BASE_DB     = 5'h0c;
   localparam logic [4:0]  THR_STEP_DB     = 5'h06;

   // Decay rates per 6 dB, in ms, and their cycle counts
   localparam real         CLK_PERIOD_NS   = 4.0;
   localparam real         QR_DCY0_MS      = 0.725;
   localparam real         QR_DCY1_MS      = 1.45;
   localparam real         QR_DCY2_MS      = 5.8;
   localparam int          QR_DCY0_CYC = int'(QR_DCY0_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int          QR_DCY1_CYC = int'(QR_DCY1_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int          QR_DCY2_CYC = int'(QR_DCY2_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam logic [1:0]  QR_DCY_RSVD     = 2'h3;
   localparam int          DCY_CNT_W       = 24;

   // Lower-region slope codes
   localparam logic [2:0]  LO_COMP_ZERO    = 3'h4;

   // Startup gain step: 3.75 dB in quarter-dB units
   localparam logic [8:0]  START_STEP_QDB  = 9'h00f;

   // Gain readout format: unsigned, MSB weighs 64
   localparam int          GAIN_INT_W      = 7;
   localparam int          GAIN_FRAC_W     = 9;
endpackage

// File: hdl/dynamics_quick_release_gate_cfg.sv
// Parameter registers, decoders and live gain readout of the dynamics block
`timescale 1ns/1ns

module dynamics_quick_release_gate_cfg
#(
   parameter int DCY0_CYC = dyn_pkg::QR_DCY0_CYC,
   parameter int DCY1_CYC = dyn_pkg::QR_DCY1_CYC,
   parameter int DCY2_CYC = dyn_pkg::QR_DCY2_CYC
)
(
   input  wire logic                                mclk,
   input  wire logic                                nrst,
   input  wire logic [dyn_pkg::REG_AW-1:0]          reg_addr,
   input  wire logic                                reg_wr_en,
   input  wire logic [dyn_pkg::REG_DW-1:0]          reg_wdata,
   input  wire logic                                reg_rd_en,
   output logic      [dyn_pkg::REG_DW-1:0]          reg_rdata_ff,
   input  wire logic [dyn_pkg::REG_DW-1:0]          applied_gain,
   input  wire logic                                applied_gain_vld,
   output logic      [4:0]                          qr_thr_db_ff,
   output logic      [dyn_pkg::DCY_CNT_W-1:0]       qr_dcy_cyc_ff,
   output logic                                     qr_dcy_rsvd_ff,
   output logic      [3:0]                          gate_slope_ff,
   output logic      [1:0]                          lo_shift_ff,
   output logic                                     lo_zero_ff,
   output logic                                     lo_rsvd_ff,
   output logic      [8:0]                          start_atten_qdb_ff
);
   import dyn_pkg::*;

   // Refuse counts the decay output cannot carry
   if (DCY0_CYC < 1 || DCY1_CYC < 1 || DCY2_CYC < 1 ||
       DCY0_CYC >= (1 << DCY_CNT_W) || DCY1_CYC >= (1 << DCY_CNT_W) ||
       DCY2_CYC >= (1 << DCY_CNT_W))
   begin : g_dcy_chk
      $error("decay cycle counts out of range");
   end
   if (GAIN_INT_W + GAIN_FRAC_W != REG_DW)
   begin : g_fmt_chk
      $error("gain readout format does not fill the register");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoders for the logic; the checks reuse dcy_cyc and exp_slope

   function automatic logic [4:0] thr_db(input logic [1:0] code);
      thr_db = THR_BASE_DB + 5'(THR_STEP_DB * code);
   endfunction

   function automatic logic [DCY_CNT_W-1:0] dcy_cyc(input logic [1:0] code);
      case (code)
         2'h0:    dcy_cyc = DCY_CNT_W'(DCY0_CYC);
         2'h1:    dcy_cyc = DCY_CNT_W'(DCY1_CYC);
         2'h2:    dcy_cyc = DCY_CNT_W'(DCY2_CYC);
         default: dcy_cyc = '0;
      endcase
   endfunction

   function automatic logic [3:0] exp_slope(input logic [1:0] code);
      exp_slope = 4'h1 << code;
   endfunction

   function automatic logic [8:0] start_atten(input logic [4:0] code);
      start_atten = 9'(START_STEP_QDB * code);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   logic [1:0]        qr_thr_ff;
   logic [1:0]        nxt_qr_thr;
   logic [1:0]        qr_dcy_ff;
   logic [1:0]        nxt_qr_dcy;
   logic [1:0]        gate_exp_ff;
   logic [1:0]        nxt_gate_exp;
   logic [2:0]        lo_comp_ff;
   logic [2:0]        nxt_lo_comp;
   logic [4:0]        start_gain_ff;
   logic [4:0]        nxt_start_gain;
   logic [REG_DW-1:0] live_gain_ff;
   logic [REG_DW-1:0] nxt_live_gain;
   logic [REG_DW-1:0] nxt_reg_rdata;

   always_comb
   begin
      nxt_qr_thr     = qr_thr_ff;
      nxt_qr_dcy     = qr_dcy_ff;
      nxt_gate_exp   = gate_exp_ff;
      nxt_lo_comp    = lo_comp_ff;
      nxt_start_gain = start_gain_ff;
      nxt_reg_rdata  = reg_rdata_ff;
      if (reg_wr_en && reg_addr == QR_SET_ADDR)
      begin
         nxt_qr_thr = reg_wdata[QR_THR_LSB +: QR_THR_W];
         // Reserved decay code is stored as written; decoder flags it
         nxt_qr_dcy = reg_wdata[QR_DCY_LSB +: QR_DCY_W];
      end
      if (reg_wr_en && reg_addr == GATE_START_ADDR)
      begin
         nxt_gate_exp   = reg_wdata[GATE_EXP_LSB +: GATE_EXP_W];
         nxt_lo_comp    = reg_wdata[LO_COMP_LSB +: LO_COMP_W];
         nxt_start_gain = reg_wdata[START_GAIN_LSB +: START_GAIN_W];
      end
      // Status follows the audio path only; bus writes never reach it
      nxt_live_gain = applied_gain_vld ? applied_gain : live_gain_ff;
      if (reg_rd_en)
      begin
         nxt_reg_rdata = '0;
         case (reg_addr)
            QR_SET_ADDR:
            begin
               nxt_reg_rdata[QR_THR_LSB +: QR_THR_W] = qr_thr_ff;
               nxt_reg_rdata[QR_DCY_LSB +: QR_DCY_W] = qr_dcy_ff;
            end
            GATE_START_ADDR:
            begin
               nxt_reg_rdata[GATE_EXP_LSB +: GATE_EXP_W]     = gate_exp_ff;
               nxt_reg_rdata[LO_COMP_LSB +: LO_COMP_W]       = lo_comp_ff;
               nxt_reg_rdata[START_GAIN_LSB +: START_GAIN_W] = start_gain_ff;
            end
            LIVE_GAIN_ADDR: nxt_reg_rdata = live_gain_ff;
            default:        nxt_reg_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         qr_thr_ff     <= QR_THR_RST;
         qr_dcy_ff     <= QR_DCY_RST;
         gate_exp_ff   <= GATE_EXP_RST;
         lo_comp_ff    <= LO_COMP_RST;
         start_gain_ff <= START_GAIN_RST;
         live_gain_ff  <= LIVE_GAIN_RST;
         reg_rdata_ff  <= '0;
      end
      else
      begin
         qr_thr_ff     <= nxt_qr_thr;
         qr_dcy_ff     <= nxt_qr_dcy;
         gate_exp_ff   <= nxt_gate_exp;
         lo_comp_ff    <= nxt_lo_comp;
         start_gain_ff <= nxt_start_gain;
         live_gain_ff  <= nxt_live_gain;
         reg_rdata_ff  <= nxt_reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded parameters toward the audio path, one cycle behind the fields

   logic [4:0]           nxt_qr_thr_db;
   logic [DCY_CNT_W-1:0] nxt_qr_dcy_cyc;
   logic                 nxt_qr_dcy_rsvd;
   logic [3:0]           nxt_gate_slope;
   logic [1:0]           nxt_lo_shift;
   logic                 nxt_lo_zero;
   logic                 nxt_lo_rsvd;
   logic [8:0]           nxt_start_atten;

   always_comb
   begin
      nxt_qr_thr_db   = thr_db(qr_thr_ff);
      nxt_qr_dcy_cyc  = dcy_cyc(qr_dcy_ff);
      nxt_qr_dcy_rsvd = (qr_dcy_ff == QR_DCY_RSVD);
      nxt_gate_slope  = exp_slope(gate_exp_ff);
      // Reserved lower codes fall back to slope 1 so the path stays sane
      nxt_lo_shift    = 2'h0;
      nxt_lo_zero     = 1'b0;
      nxt_lo_rsvd     = 1'b0;
      if (lo_comp_ff < LO_COMP_ZERO)
         nxt_lo_shift = lo_comp_ff[1:0];
      else if (lo_comp_ff == LO_COMP_ZERO)
         nxt_lo_zero = 1'b1;
      else
         nxt_lo_rsvd = 1'b1;
      nxt_start_atten = start_atten(start_gain_ff);
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         qr_thr_db_ff       <= THR_BASE_DB;
         qr_dcy_cyc_ff      <= '0;
         qr_dcy_rsvd_ff     <= 1'b0;
         gate_slope_ff      <= 4'h1;
         lo_shift_ff        <= 2'h0;
         lo_zero_ff         <= 1'b0;
         lo_rsvd_ff         <= 1'b0;
         start_atten_qdb_ff <= 9'h000;
      end
      else
      begin
         qr_thr_db_ff       <= nxt_qr_thr_db;
         qr_dcy_cyc_ff      <= nxt_qr_dcy_cyc;
         qr_dcy_rsvd_ff     <= nxt_qr_dcy_rsvd;
         gate_slope_ff      <= nxt_gate_slope;
         lo_shift_ff        <= nxt_lo_shift;
         lo_zero_ff         <= nxt_lo_zero;
         lo_rsvd_ff         <= nxt_lo_rsvd;
         start_atten_qdb_ff <= nxt_start_atten;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_thr;
      logic [1:0] c;
      (reg_wr_en && reg_addr == QR_SET_ADDR, c = reg_wdata[3:2])
      |-> ##2 qr_thr_db_ff == 5'(12 + 6 * c);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold decode wrong");

   property p_dcy;
      (reg_wr_en && reg_addr == QR_SET_ADDR)
      |-> ##2 (qr_dcy_cyc_ff == dcy_cyc($past(reg_wdata[1:0], 2)) &&
               qr_dcy_rsvd_ff == ($past(reg_wdata[1:0], 2) == 2'h3));
   endproperty
   a_dcy: assert property (p_dcy) else $error("decay decode wrong");

   property p_exp;
      (reg_wr_en && reg_addr == GATE_START_ADDR)
      |-> ##2 gate_slope_ff == exp_slope($past(reg_wdata[9:8], 2));
   endproperty
   a_exp: assert property (p_exp) else $error("gate slope wrong");

   property p_lo;
      (reg_wr_en && reg_addr == GATE_START_ADDR && reg_wdata[7:5] == 3'h4)
      |-> ##2 (lo_zero_ff && !lo_rsvd_ff && lo_shift_ff == 2'h0);
   endproperty
   a_lo: assert property (p_lo) else $error("lower slope zero wrong");

   property p_start;
      (reg_wr_en && reg_addr == GATE_START_ADDR && reg_wdata[4:0] == 5'h1f)
      |-> ##2 start_atten_qdb_ff == 9'h1d1;
   endproperty
   a_start: assert property (p_start) else $error("startup gain wrong");

   property p_ro;
      (!applied_gain_vld && reg_wr_en && reg_addr == LIVE_GAIN_ADDR)
      |=> $stable(live_gain_ff);
   endproperty
   a_ro: assert property (p_ro) else $error("status changed on write");

   property p_rd;
      (applied_gain_vld ##1 (!applied_gain_vld && reg_rd_en &&
                             reg_addr == LIVE_GAIN_ADDR))
      |=> reg_rdata_ff == $past(applied_gain, 2);
   endproperty
   a_rd: assert property (p_rd) else $error("gain readout wrong");
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the dynamics parameter registers and gain readout
`timescale 1ns/1ns

module tb_top;
   import dyn_pkg::*;

   logic                     mclk;
   logic                     nrst;
   logic [REG_AW-1:0]        reg_addr;
   logic                     reg_wr_en;
   logic [REG_DW-1:0]        reg_wdata;
   logic                     reg_rd_en;
   logic [REG_DW-1:0]        reg_rdata_ff;
   logic [REG_DW-1:0]        applied_gain;
   logic                     applied_gain_vld;
   logic [4:0]               qr_thr_db_ff;
   logic [DCY_CNT_W-1:0]     qr_dcy_cyc_ff;
   logic                     qr_dcy_rsvd_ff;
   logic [3:0]               gate_slope_ff;
   logic [1:0]               lo_shift_ff;
   logic                     lo_zero_ff;
   logic                     lo_rsvd_ff;
   logic [8:0]               start_atten_qdb_ff;
   logic                     rd_pend;
   logic [REG_DW-1:0]        exp_q[$];
   logic [REG_DW-1:0]        d;
   logic [REG_DW-1:0]        g;
   int                       fail_count = 0;
   int                       tests_run = 0;

   // Short decay counts keep the run brief
   dynamics_quick_release_gate_cfg #(.DCY0_CYC(5), .DCY1_CYC(10),
                                     .DCY2_CYC(40)) DUT
   (
      .mclk               (mclk),
      .nrst               (nrst),
      .reg_addr           (reg_addr),
      .reg_wr_en          (reg_wr_en),
      .reg_wdata          (reg_wdata),
      .reg_rd_en          (reg_rd_en),
      .reg_rdata_ff       (reg_rdata_ff),
      .applied_gain       (applied_gain),
      .applied_gain_vld   (applied_gain_vld),
      .qr_thr_db_ff       (qr_thr_db_ff),
      .qr_dcy_cyc_ff      (qr_dcy_cyc_ff),
      .qr_dcy_rsvd_ff     (qr_dcy_rsvd_ff),
      .gate_slope_ff      (gate_slope_ff),
      .lo_shift_ff        (lo_shift_ff),
      .lo_zero_ff         (lo_zero_ff),
      .lo_rsvd_ff         (lo_rsvd_ff),
      .start_atten_qdb_ff (start_atten_qdb_ff)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // The wr and rd tasks start and end on a falling edge; strobes last one cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr_en = 1'b1;
      @(negedge mclk);
      reg_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge mclk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      exp_q.push_back(e);
      @(negedge mclk);
      reg_rd_en = 1'b0;
   endtask

   // Decoded outputs settle one edge after the write edge; wait two edges
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) rd_pend <= reg_rd_en;

   always @(negedge mclk)
      if (rd_pend === 1'b1)
         check(reg_rdata_ff, exp_q.pop_front());

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial
   begin
      #100000;
      fail_count++;
      close_out();
   end

   initial
   begin
      nrst = 1'b0;
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd_en = 1'b0;
      applied_gain = 16'h0000;
      applied_gain_vld = 1'b0;
      void'($urandom(96));
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      settle();
      check(qr_thr_db_ff, 24'h00000c);
      check(qr_dcy_cyc_ff, 24'h000005);
      check({gate_slope_ff, lo_shift_ff, lo_zero_ff, lo_rsvd_ff},
            24'h000010);
      check(start_atten_qdb_ff, 24'h000000);
      rd(QR_SET_ADDR, 16'h0000);
      rd(GATE_START_ADDR, 16'h0000);
      rd(LIVE_GAIN_ADDR, LIVE_GAIN_RST);
      // Threshold and legal decay codes, noise in the unused upper bits
      for (int c = 0; c < 16; c++)
      begin
         d = 16'($urandom()) & 16'hfff0 | 16'(c & 12) | 16'(c % 3);
         wr(QR_SET_ADDR, d);
         settle();
         check(qr_thr_db_ff, 24'(5'h0c + 5'h06 * 5'(c >> 2)));
         check(qr_dcy_cyc_ff, (c % 3 == 0) ? 24'h000005 :
               (c % 3 == 1) ? 24'h00000a : 24'h000028);
         check(qr_dcy_rsvd_ff, 24'h000000);
         rd(QR_SET_ADDR, d & 16'h000f);
      end
      // Every gate slope with every legal lower slope, random startup gain
      for (int c = 0; c < 32; c++)
      begin
         g = 16'($urandom_range(31, 0));
         if (c == 0) g = 16'h001f;
         d = 16'($urandom()) & 16'hfc00 | 16'((c >> 3) << 8) |
             16'((c % 8 % 5) << 5) | g;
         wr(GATE_START_ADDR, d);
         settle();
         check(gate_slope_ff, 24'(4'h1 << (c >> 3)));
         check(lo_shift_ff, 24'((c % 8 % 5 < 4) ? c % 8 % 5 : 0));
         check(lo_zero_ff, 24'(c % 8 % 5 == 4));
         check(lo_rsvd_ff, 24'h000000);
         check(start_atten_qdb_ff, 24'(g * 15));
         rd(GATE_START_ADDR, d & 16'h03ff);
      end
      // Live gain capture, then a write to the readout that must not land
      for (int k = 0; k < 4; k++)
      begin
         g = 16'($urandom());
         if (k == 0) g = 16'hffff;
         @(negedge mclk);
         applied_gain = g;
         applied_gain_vld = 1'b1;
         @(negedge mclk);
         // Read in the cycle right after capture, then twice more later
         applied_gain_vld = 1'b0;
         applied_gain = ~g;
         reg_addr = LIVE_GAIN_ADDR;
         reg_rd_en = 1'b1;
         exp_q.push_back(g);
         @(negedge mclk);
         reg_rd_en = 1'b0;
         rd(LIVE_GAIN_ADDR, g);
         wr(LIVE_GAIN_ADDR, ~g);
         rd(LIVE_GAIN_ADDR, g);
      end
      // Unmapped place reads zero and a write there changes nothing
      wr(QR_SET_ADDR, 16'h0009);
      wr(8'h25, 16'hffff);
      rd(8'h25, 16'h0000);
      rd(QR_SET_ADDR, 16'h0009);
      // Write and read in one cycle: the read returns the old word
      @(negedge mclk);
      reg_addr = QR_SET_ADDR;
      reg_wdata = 16'h0006;
      reg_wr_en = 1'b1;
      reg_rd_en = 1'b1;
      exp_q.push_back(16'h0009);
      @(negedge mclk);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      rd(QR_SET_ADDR, 16'h0006);
      // Reset in mid-run returns every field to its reset code
      @(negedge mclk);
      nrst = 1'b0;
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      settle();
      check(qr_thr_db_ff, 24'h00000c);
      check(qr_dcy_cyc_ff, 24'h000005);
      rd(QR_SET_ADDR, 16'h0000);
      rd(GATE_START_ADDR, 16'h0000);
      rd(LIVE_GAIN_ADDR, LIVE_GAIN_RST);
      repeat (3) @(negedge mclk);
      close_out();
   end
endmodule
